//--- hdl/scratchpad_pkg.sv
// constants and types shared by the scratchpad command engine
package scratchpad_pkg;
    // memory function command codes
    localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
    localparam logic [7:0] CMD_READ_SP = 8'hAA;
    localparam logic [7:0] CMD_COPY_SP = 8'h55;
    localparam logic [7:0] CMD_READ_MEM = 8'hF0;
    // ending_offset_status field positions
    localparam int AA_BIT = 7;
    localparam int OF_BIT = 6;
    localparam int PF_BIT = 5;
    localparam int END_MSB = 4;
    // reset values and fixed stream bytes
    localparam logic [7:0] TA_RESET = 8'h00;
    localparam logic [7:0] ES_RESET = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // sizes
    localparam int SP_BYTES = 32;
    localparam int MEM_BYTES = 8192;
    localparam int MEM_AW = 13;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int COPY_TIME_NS = 30000;
    localparam int COPY_CYC = COPY_TIME_NS / CLK_PERIOD_NS;
    localparam int LOW_FAST_NS = 16000;
    localparam int LOW_FAST_CYC = LOW_FAST_NS / CLK_PERIOD_NS;
    localparam int LOW_SLOW_NS = 120000;
    localparam int LOW_SLOW_CYC = LOW_SLOW_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CMD,
        ST_WS_ADDR,
        ST_WS_DATA,
        ST_RS_SEND,
        ST_CP_AUTH,
        ST_COPY,
        ST_COPY_DONE,
        ST_RM_ADDR,
        ST_RM_SEND,
        ST_WAIT_RESET
    } state_e;
endpackage

//--- hdl/scratchpad_memory_command_engine.sv
// memory function command engine: scratchpad, copy and memory read over bit slots
`timescale 1ns/1ps
`default_nettype none

module scratchpad_memory_command_engine #(
    parameter int LOW_SLOW_LIMIT = scratchpad_pkg::LOW_SLOW_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // slot layer events
    input wire logic bus_reset,
    input wire logic mem_start,
    input wire logic wr_slot,
    input wire logic wr_bit,
    input wire logic rd_slot,
    input wire logic line_low,
    input wire logic fast_speed_flag,
    // answers to the slot layer
    output logic rd_bit,
    output logic copy_busy
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] sp [0:scratchpad_pkg::SP_BYTES-1];
    logic [7:0] mem [0:scratchpad_pkg::MEM_BYTES-1];

    scratchpad_pkg::state_e state, next_state;
    logic [7:0] rx, next_rx;
    logic [2:0] bitcnt, next_bitcnt;
    logic [6:0] k, next_k;
    logic [7:0] target_address_low, next_target_address_low;
    logic [7:0] target_address_high, next_target_address_high;
    logic [7:0] ending_offset_status, next_ending_offset_status;
    logic [5:0] wpos, next_wpos;
    logic [16:0] mem_ptr, next_mem_ptr;
    logic [7:0] tx, next_tx;
    logic auth_ok, next_auth_ok;
    logic [15:0] busy_cnt, next_busy_cnt;
    logic [5:0] cp, next_cp;
    logic next_copy_busy;
    logic [15:0] low_cnt, next_low_cnt;

    logic sp_we;
    logic [4:0] sp_wa;
    logic [2:0] sp_wb;
    logic mem_we;
    logic [scratchpad_pkg::MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    // ----------------------------------------------------------------
    // byte sources for the read streams
    // ----------------------------------------------------------------
    function automatic logic [7:0] sp_stream(input logic [6:0] idx);
        // one bit wider than the index so a long read cannot wrap back into the data
        logic [7:0] ptr;
        ptr = 8'({3'b000, target_address_low[4:0]} + {1'b0, idx} - 8'd3);
        if (idx == 7'd0)
            return target_address_low;
        else if (idx == 7'd1)
            return target_address_high;
        else if (idx == 7'd2)
            return ending_offset_status;
        else if (ptr >= 8'(scratchpad_pkg::SP_BYTES))
            return scratchpad_pkg::IDLE_BYTE;
        else
            return sp[ptr[4:0]];
    endfunction

    function automatic logic [7:0] mem_stream(input logic [16:0] p);
        if (p >= 17'(scratchpad_pkg::MEM_BYTES))
            return scratchpad_pkg::IDLE_BYTE;
        else
            return mem[p[scratchpad_pkg::MEM_AW-1:0]];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] byte_in;
        logic [15:0] low_limit;
        logic [15:0] cp_addr;
        logic timeout;
        logic line_reset;
        byte_in = {wr_bit, rx[7:1]};
        cp_addr = {target_address_high, target_address_low[7:5], cp[4:0]};
        low_limit = 16'd0;
        timeout = 1'b0;
        line_reset = 1'b0;
        next_state = state;
        next_rx = rx;
        next_bitcnt = bitcnt;
        next_k = k;
        next_target_address_low = target_address_low;
        next_target_address_high = target_address_high;
        next_ending_offset_status = ending_offset_status;
        next_wpos = wpos;
        next_mem_ptr = mem_ptr;
        next_tx = tx;
        next_auth_ok = auth_ok;
        next_busy_cnt = busy_cnt;
        next_cp = cp;
        sp_we = 1'b0;
        sp_wa = wpos[4:0];
        sp_wb = bitcnt;
        mem_we = 1'b0;
        mem_wa = cp_addr[scratchpad_pkg::MEM_AW-1:0];
        mem_wd = sp[cp[4:0]];

        low_limit = fast_speed_flag ? 16'(scratchpad_pkg::LOW_FAST_CYC) : 16'(LOW_SLOW_LIMIT);
        // low-time watchdog, one pulse per long low
        next_low_cnt = line_low ? ((low_cnt == low_limit) ? low_cnt : 16'(low_cnt + 16'd1)) : 16'd0;
        timeout = line_low && (low_cnt == 16'(low_limit - 16'd1));
        line_reset = (bus_reset || timeout) && (state != scratchpad_pkg::ST_COPY);

        if (wr_slot)
            next_rx = byte_in;

        case (state)
            scratchpad_pkg::ST_IDLE:
            begin
                if (mem_start)
                begin
                    next_state = scratchpad_pkg::ST_CMD;
                    next_bitcnt = 3'd0;
                end
            end
            scratchpad_pkg::ST_CMD:
            begin
                if (wr_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    next_k = 7'd0;
                    if (bitcnt == 3'd7)
                    begin
                        if (byte_in == scratchpad_pkg::CMD_WRITE_SP)
                        begin
                            next_state = scratchpad_pkg::ST_WS_ADDR;
                            // only a write command clears it
                            next_ending_offset_status[scratchpad_pkg::AA_BIT] = 1'b0;
                        end
                        else if (byte_in == scratchpad_pkg::CMD_READ_SP)
                        begin
                            next_state = scratchpad_pkg::ST_RS_SEND;
                            next_tx = sp_stream(7'd0);
                        end
                        else if (byte_in == scratchpad_pkg::CMD_COPY_SP)
                        begin
                            next_state = scratchpad_pkg::ST_CP_AUTH;
                            next_auth_ok = 1'b1;
                        end
                        else if (byte_in == scratchpad_pkg::CMD_READ_MEM)
                            next_state = scratchpad_pkg::ST_RM_ADDR;
                        else
                            next_state = scratchpad_pkg::ST_WAIT_RESET;
                    end
                end
            end
            scratchpad_pkg::ST_WS_ADDR, scratchpad_pkg::ST_RM_ADDR:
            begin
                if (wr_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    if (bitcnt == 3'd7)
                    begin
                        next_k = 7'd1;
                        if (k == 7'd0)
                            next_target_address_low = byte_in;
                        else
                        begin
                            next_target_address_high = byte_in;
                            if (state == scratchpad_pkg::ST_WS_ADDR)
                            begin
                                next_wpos = {1'b0, target_address_low[4:0]};
                                next_ending_offset_status = {3'b000, target_address_low[4:0]};
                                next_state = scratchpad_pkg::ST_WS_DATA;
                            end
                            else
                            begin
                                next_mem_ptr = {1'b0, byte_in, target_address_low};
                                next_tx = mem_stream({1'b0, byte_in, target_address_low});
                                next_state = scratchpad_pkg::ST_RM_SEND;
                            end
                        end
                    end
                end
            end
            scratchpad_pkg::ST_WS_DATA:
            begin
                if (wr_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    if (wpos[5])
                        next_ending_offset_status[scratchpad_pkg::OF_BIT] = 1'b1;
                    else
                    begin
                        sp_we = 1'b1;
                        // ending offset tracks the last byte touched
                        next_ending_offset_status[scratchpad_pkg::END_MSB:0] = wpos[4:0];
                        next_ending_offset_status[scratchpad_pkg::PF_BIT] = (bitcnt != 3'd7);
                        if (bitcnt == 3'd7)
                            next_wpos = 6'(wpos + 6'd1);
                    end
                end
            end
            scratchpad_pkg::ST_RS_SEND:
            begin
                if (rd_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    if (bitcnt == 3'd7)
                    begin
                        // index saturates so the stream stays on ones
                        next_k = (k == 7'h7F) ? k : 7'(k + 7'd1);
                        next_tx = sp_stream((k == 7'h7F) ? k : 7'(k + 7'd1));
                    end
                    else
                        next_tx = {1'b1, tx[7:1]};
                end
            end
            scratchpad_pkg::ST_RM_SEND:
            begin
                if (rd_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    if (bitcnt == 3'd7)
                    begin
                        next_mem_ptr = mem_ptr[16] ? mem_ptr : 17'(mem_ptr + 17'd1);
                        next_tx = mem_stream(mem_ptr[16] ? mem_ptr : 17'(mem_ptr + 17'd1));
                    end
                    else
                        next_tx = {1'b1, tx[7:1]};
                end
            end
            scratchpad_pkg::ST_CP_AUTH:
            begin
                if (wr_slot)
                begin
                    next_bitcnt = 3'(bitcnt + 3'd1);
                    if (bitcnt == 3'd7)
                    begin
                        next_auth_ok = auth_ok && (byte_in == ((k == 7'd0) ? target_address_low :
                                       (k == 7'd1) ? target_address_high : ending_offset_status));
                        next_k = 7'(k + 7'd1);
                        if (k == 7'd2)
                        begin
                            // full match sets the flag and starts copying
                            if (next_auth_ok)
                            begin
                                next_ending_offset_status[scratchpad_pkg::AA_BIT] = 1'b1;
                                next_cp = {1'b0, target_address_low[4:0]};
                                next_busy_cnt = 16'd0;
                                next_state = scratchpad_pkg::ST_COPY;
                            end
                            else
                                next_state = scratchpad_pkg::ST_WAIT_RESET;
                        end
                    end
                end
            end
            scratchpad_pkg::ST_COPY:
            begin
                next_busy_cnt = 16'(busy_cnt + 16'd1);
                // begin through end offset, whole bytes
                if (cp <= {1'b0, ending_offset_status[scratchpad_pkg::END_MSB:0]})
                begin
                    mem_we = (cp_addr < 16'(scratchpad_pkg::MEM_BYTES));
                    next_cp = 6'(cp + 6'd1);
                end
                if (busy_cnt == 16'(scratchpad_pkg::COPY_CYC - 1))
                begin
                    next_state = scratchpad_pkg::ST_COPY_DONE;
                    next_tx = scratchpad_pkg::ZERO_BYTE;
                end
            end
            default:
            begin
            end
        endcase

        if (line_reset)
        begin
            next_state = scratchpad_pkg::ST_IDLE;
            next_bitcnt = 3'd0;
            next_tx = scratchpad_pkg::IDLE_BYTE;
        end
        next_copy_busy = (next_state == scratchpad_pkg::ST_COPY);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= scratchpad_pkg::ST_IDLE;
            rx <= 8'h00;
            bitcnt <= 3'd0;
            k <= 7'd0;
            target_address_low <= scratchpad_pkg::TA_RESET;
            target_address_high <= scratchpad_pkg::TA_RESET;
            ending_offset_status <= scratchpad_pkg::ES_RESET;
            wpos <= 6'd0;
            mem_ptr <= 17'd0;
            tx <= scratchpad_pkg::IDLE_BYTE;
            auth_ok <= 1'b0;
            busy_cnt <= 16'd0;
            cp <= 6'd0;
            copy_busy <= 1'b0;
            low_cnt <= 16'd0;
        end
        else
        begin
            state <= next_state;
            rx <= next_rx;
            bitcnt <= next_bitcnt;
            k <= next_k;
            target_address_low <= next_target_address_low;
            target_address_high <= next_target_address_high;
            ending_offset_status <= next_ending_offset_status;
            wpos <= next_wpos;
            mem_ptr <= next_mem_ptr;
            tx <= next_tx;
            auth_ok <= next_auth_ok;
            busy_cnt <= next_busy_cnt;
            cp <= next_cp;
            copy_busy <= next_copy_busy;
            low_cnt <= next_low_cnt;
        end
    end

    // arrays carry no reset; contents are undefined until written
    always_ff @(posedge clk)
    begin
        if (sp_we)
            sp[sp_wa][sp_wb] <= wr_bit;
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    // bit offered for the next read slot; ones mean the line is released
    assign rd_bit = tx[0];

endmodule

`default_nettype wire

//--- verification/scratchpad_engine_props.sv
// concurrent checks on the scratchpad command engine ports
`timescale 1ns/1ps
`default_nettype none
module scratchpad_engine_props #(
    parameter int LOW_SLOW_LIMIT = 15000
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // slot events
    input wire logic bus_reset,
    input wire logic mem_start,
    input wire logic wr_slot,
    input wire logic wr_bit,
    input wire logic rd_slot,
    input wire logic line_low,
    input wire logic fast_speed_flag,
    // answers
    input wire logic rd_bit,
    input wire logic copy_busy
);
    logic [15:0] busy_len;
    logic [15:0] next_busy_len;
    logic [19:0] low_cnt;
    logic [19:0] next_low_cnt;
    logic was_busy;
    logic done;
    logic next_done;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------
    // helper counters
    // ------------------------------------------------
    always_comb
    begin
        next_busy_len = copy_busy ? busy_len + 16'h0001 : 16'h0000;
        next_low_cnt = line_low ? low_cnt + 20'h00001 : 20'h00000;
        next_done = done;
        // done drops early on any long low, so the check never outlives a watchdog reset
        if (was_busy && !copy_busy)
            next_done = 1'b1;
        else if (bus_reset || low_cnt > 20'h00001)
            next_done = 1'b0;
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_len <= 16'h0000;
            low_cnt <= 20'h00000;
            was_busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            busy_len <= next_busy_len;
            low_cnt <= next_low_cnt;
            was_busy <= copy_busy;
            done <= next_done;
        end
    end
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    sequence s_busy_begin;
        !copy_busy ##1 copy_busy;
    endsequence
    sequence s_copy_end;
        copy_busy ##1 !copy_busy;
    endsequence
    a_busy_after_slot: assert property (s_busy_begin |-> $past(wr_slot))
        else $error("copy busy rose without a preceding write slot");
    a_busy_length: assert property ($fell(copy_busy) |-> busy_len == 16'(scratchpad_pkg::COPY_CYC))
        else $error("copy busy period has the wrong length");
    a_busy_ignores_reset: assert property (copy_busy && bus_reset && busy_len < 16'd3700 |=> copy_busy)
        else $error("bus reset ended the copy early");
    a_copy_end_zero: assert property (s_copy_end |-> !rd_bit)
        else $error("read bit not zero when copy finished");
    a_zero_until_reset: assert property (done |-> !rd_bit)
        else $error("read bit released after copy before reset");
    a_reset_releases: assert property (bus_reset && !copy_busy |=> rd_bit)
        else $error("bus not released after reset pulse");
    a_rd_change_cause: assert property ($changed(rd_bit) |-> $past(rd_slot) || $past(wr_slot)
        || $past(bus_reset) || $past(line_low) || $fell(copy_busy))
        else $error("read bit changed with no slot or reset");
    a_watchdog_slow: assert property (!fast_speed_flag && !copy_busy && low_cnt == LOW_SLOW_LIMIT
        |-> ##[0:3] rd_bit)
        else $error("slow speed long low did not reset engine");
    a_watchdog_fast: assert property (fast_speed_flag && !copy_busy && low_cnt == scratchpad_pkg::LOW_FAST_CYC
        |-> ##[0:3] rd_bit)
        else $error("fast speed long low did not reset engine");
endmodule
bind scratchpad_memory_command_engine scratchpad_engine_props #(.LOW_SLOW_LIMIT(LOW_SLOW_LIMIT)) u_props (
    .clk(clk), .sys_rst(sys_rst), .bus_reset(bus_reset), .mem_start(mem_start), .wr_slot(wr_slot),
    .wr_bit(wr_bit), .rd_slot(rd_slot), .line_low(line_low), .fast_speed_flag(fast_speed_flag),
    .rd_bit(rd_bit), .copy_busy(copy_busy));
`default_nettype wire

//--- verification/slot_master_model.sv
// bus master model driving the slot layer events of the engine
`timescale 1ns/1ps
`default_nettype none
module slot_master_model (
    // clock
    input wire logic clk,
    // slot events
    output logic bus_reset,
    output logic mem_start,
    output logic wr_slot,
    output logic wr_bit,
    output logic rd_slot,
    output logic line_low,
    // answer
    input wire logic rd_bit
);
    initial
    begin
        bus_reset = 1'b0;
        mem_start = 1'b0;
        wr_slot = 1'b0;
        wr_bit = 1'b1;
        rd_slot = 1'b0;
        line_low = 1'b0;
    end
    // line low only inside a slot
    task automatic slot(input logic is_rd, input logic val);
        @(posedge clk);
        wr_slot <= !is_rd;
        rd_slot <= is_rd;
        wr_bit <= val;
        line_low <= 1'b1;
        @(posedge clk);
        wr_slot <= 1'b0;
        rd_slot <= 1'b0;
        line_low <= 1'b0;
        // a released sample no longer shows the last bit
        wr_bit <= ~val;
    endtask
    task automatic send_bits(input logic [47:0] d, input int nbits);
        for (int i = 0; i < nbits; i++)
            slot(1'b0, d[i]);
    endtask
    task automatic send_byte(input logic [7:0] d);
        send_bits({40'h0000000000, d}, 8);
    endtask
    task automatic recv_byte(output logic [7:0] d);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            d[i] = rd_bit;
            slot(1'b1, 1'b1);
        end
    endtask
    task automatic pulse_reset();
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
    endtask
    // each transaction opens with reset, selection, then command
    task automatic open(input logic [7:0] cmd);
        pulse_reset();
        mem_start <= 1'b1;
        @(posedge clk);
        mem_start <= 1'b0;
        @(posedge clk);
        send_byte(cmd);
    endtask
    task automatic hold_low(input int ncyc);
        @(posedge clk);
        line_low <= (ncyc > 0);
        repeat (ncyc) @(posedge clk);
        line_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_scratchpad_memory_command_engine.sv
// self-checking bench of the scratchpad command engine
`timescale 1ns/1ps
`default_nettype none
module tb_scratchpad_memory_command_engine;
    // shortened slow-speed watchdog keeps the run brief
    localparam int SLOW_LIMIT = 200;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic fast_speed_flag = 1'b0;
    logic bus_reset, mem_start, wr_slot, wr_bit, rd_slot, line_low, rd_bit, copy_busy;
    logic [7:0] b;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    always #4 clk = ~clk;
    scratchpad_memory_command_engine #(.LOW_SLOW_LIMIT(SLOW_LIMIT)) u_scratchpad_memory_command_engine (
        .clk(clk), .sys_rst(sys_rst), .bus_reset(bus_reset), .mem_start(mem_start), .wr_slot(wr_slot),
        .wr_bit(wr_bit), .rd_slot(rd_slot), .line_low(line_low), .fast_speed_flag(fast_speed_flag),
        .rd_bit(rd_bit), .copy_busy(copy_busy));
    slot_master_model u_slot_master_model (
        .clk(clk), .bus_reset(bus_reset), .mem_start(mem_start), .wr_slot(wr_slot), .wr_bit(wr_bit),
        .rd_slot(rd_slot), .line_low(line_low), .rd_bit(rd_bit));
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // speed changes only on a rising edge, while no slot is running
    task automatic set_speed(input logic fast);
        @(posedge clk);
        fast_speed_flag <= fast;
    endtask
    task automatic get(input string what, input logic [7:0] exp);
        u_slot_master_model.recv_byte(b);
        check(what, b, exp);
    endtask
    task automatic hdr(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] es);
        u_slot_master_model.open(scratchpad_pkg::CMD_READ_SP);
        get("addr_low", lo);
        get("addr_high", hi);
        get("status", es);
    endtask
    task automatic write_sp(input logic [15:0] addr, input logic [47:0] d, input int nbits);
        u_slot_master_model.open(scratchpad_pkg::CMD_WRITE_SP);
        u_slot_master_model.send_byte(addr[7:0]);
        u_slot_master_model.send_byte(addr[15:8]);
        u_slot_master_model.send_bits(d, nbits);
    endtask
    task automatic copy(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] es);
        u_slot_master_model.open(scratchpad_pkg::CMD_COPY_SP);
        u_slot_master_model.send_byte(lo);
        u_slot_master_model.send_byte(hi);
        u_slot_master_model.send_byte(es);
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        hdr(8'h00, 8'h00, 8'h00);
        write_sp(16'h0026, 48'h3CA5, 16);
        hdr(8'h26, 8'h00, 8'h07);
        get("data0", 8'hA5);
        get("data1", 8'h3C);
        repeat (24) u_slot_master_model.recv_byte(b);
        get("past_end", 8'hFF);
        copy(8'h26, 8'h00, 8'h07);
        n = 0;
        while (copy_busy !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        check("busy", {7'h00, copy_busy}, 8'h01);
        u_slot_master_model.pulse_reset();
        @(negedge clk);
        check("busy_kept", {7'h00, copy_busy}, 8'h01);
        while (copy_busy !== 1'b0 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        check("busy_end", {7'h00, copy_busy}, 8'h00);
        get("after_copy", 8'h00);
        hdr(8'h26, 8'h00, 8'h87);
        u_slot_master_model.open(scratchpad_pkg::CMD_READ_MEM);
        u_slot_master_model.send_byte(8'h25);
        u_slot_master_model.send_byte(8'h00);
        u_slot_master_model.recv_byte(b);
        get("mem0", 8'hA5);
        get("mem1", 8'h3C);
        hdr(8'h25, 8'h00, 8'h87);
        u_slot_master_model.open(scratchpad_pkg::CMD_READ_MEM);
        u_slot_master_model.send_byte(8'hFF);
        u_slot_master_model.send_byte(8'h1F);
        u_slot_master_model.recv_byte(b);
        get("mem_end", 8'hFF);
        write_sp(16'h013C, 48'h5566778899, 40);
        // overflow flag set: the ending offset stays at 1F, the last byte
        hdr(8'h3C, 8'h01, 8'h5F);
        copy(8'h3C, 8'h01, 8'h1F);
        repeat (4) @(negedge clk);
        check("no_copy", {7'h00, copy_busy}, 8'h00);
        hdr(8'h3C, 8'h01, 8'h5F);
        write_sp(16'h0040, 48'h05C3, 11);
        hdr(8'h40, 8'h00, 8'h21);
        u_slot_master_model.open(8'h33);
        get("unknown_cmd", 8'hFF);
        u_slot_master_model.open(scratchpad_pkg::CMD_READ_SP);
        set_speed(1'b1);
        u_slot_master_model.hold_low(210);
        @(negedge clk);
        check("fast_short_low", {7'h00, rd_bit}, 8'h00);
        u_slot_master_model.hold_low(2010);
        @(negedge clk);
        check("fast_long_low", {7'h00, rd_bit}, 8'h01);
        set_speed(1'b0);
        u_slot_master_model.open(scratchpad_pkg::CMD_READ_SP);
        u_slot_master_model.hold_low(210);
        @(negedge clk);
        check("slow_long_low", {7'h00, rd_bit}, 8'h01);
        end_sim();
    end
endmodule
`default_nettype wire
